// File: sapp_pkg.sv
package sapp_pkg;
    // Clock rate and derived cycle counts.
    localparam int CLK_PERIOD_NS    = 100;
    localparam int REACQ_NS         = 30;
    localparam int REACQ_CYC        = (REACQ_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int EOC_MAX_NS       = 110;
    localparam int EOC_MAX_CYC      = (EOC_MAX_NS / CLK_PERIOD_NS) < 1 ? 1
                                      : (EOC_MAX_NS / CLK_PERIOD_NS);
    localparam int CONV_WAIT_NS     = 530;
    localparam int CONV_WAIT_CYC    = (CONV_WAIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int PWRUP_NS         = 25000;
    localparam int PWRUP_CYC        = (PWRUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // Read stays low until the bus has passed both synchroniser stages.
    localparam int RD_LOW_CYC       = 3;
    localparam int TIMEOUT_CYC      = 64;
    localparam int DATA_W           = 8;
    localparam int CHAN_W           = 3;
    localparam int CNT_W            = 16;
    localparam logic [CHAN_W-1:0] CHAN_RST = 3'h0;
    localparam logic [DATA_W-1:0] DATA_RST = 8'h00;

    typedef enum logic [5:0] {
        SAPP_IDLE  = 6'b000001,
        SAPP_PWRUP = 6'b000010,
        SAPP_CONV  = 6'b000100,
        SAPP_WAIT  = 6'b001000,
        SAPP_READ  = 6'b010000,
        SAPP_REACQ = 6'b100000
    } sapp_state_t;
endpackage : sapp_pkg

// File: sapp_stream_if.sv
`timescale 1ns/100ps
interface sapp_stream_if #(parameter int W = 11);
    logic         valid;
    logic         ready;
    logic [W-1:0] data;
    modport src (output valid, output data, input ready);
    modport snk (input valid, input data, output ready);
endinterface : sapp_stream_if

// File: sapp_buf2.sv
`timescale 1ns/100ps
// Two-entry buffer; a receiver stall holds words until both slots fill.
module sapp_buf2 #(
    parameter int W = 11
) (
    input  wire logic clock,
    input  wire logic resetn,
    sapp_stream_if.snk in_s,
    sapp_stream_if.src out_s
);
    logic [W-1:0] mem_reg [2];
    logic [W-1:0] mem_next [2];
    logic         wp_reg, wp_next, rp_reg, rp_next;
    logic [1:0]   cnt_reg, cnt_next;
    logic         push, pop;

    assign in_s.ready  = (cnt_reg != 2'h2);
    assign out_s.valid = (cnt_reg != 2'h0);
    assign out_s.data  = mem_reg[rp_reg];

    always_comb begin
        push     = in_s.valid && in_s.ready;
        pop      = out_s.valid && out_s.ready;
        mem_next = mem_reg;
        wp_next  = wp_reg;
        rp_next  = rp_reg;
        cnt_next = cnt_reg;
        if (push) begin
            mem_next[wp_reg] = in_s.data;
            wp_next          = ~wp_reg;
        end
        if (pop) begin
            rp_next = ~rp_reg;
        end
        if (push && !pop) begin
            cnt_next = cnt_reg + 2'h1;
        end else if (pop && !push) begin
            cnt_next = cnt_reg - 2'h1;
        end
    end

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            mem_reg[0] <= '0;
            mem_reg[1] <= '0;
            wp_reg     <= 1'b0;
            rp_reg     <= 1'b0;
            cnt_reg    <= 2'h0;
        end else begin
            mem_reg <= mem_next;
            wp_reg  <= wp_next;
            rp_reg  <= rp_next;
            cnt_reg <= cnt_next;
        end
    end

    AST_NO_OVERFLOW: assert property (@(posedge clock) disable iff (!resetn)
        cnt_reg != 2'h3) else $error("buffer count out of range");
endmodule : sapp_buf2

// File: sapp_host.sv
`timescale 1ns/100ps
// ***************************************************************
// How it works
// ***************************************************************
// How it works
// - The result is sampled from the data bus while chip select and read are both low.
// - Chip select may be held low with read alone gating data; option hold_cs_low.
// - Chip select and read may be taken from end-of-conversion; option eoc_gated_read.
// - The channel number goes out on the three low select lines during the read.
// - In the gated-read mode without hold_cs_low the host drives only convert-start, unless the timeout fires and it pulls chip select and read low.
// - End-of-conversion is treated as an edge-triggered request.
// - Convert-start still low at the end-of-conversion rise picks power-down, else high speed.
// - In high-speed mode no new conversion starts until 30 ns after a read ends.
module sapp_host
    import sapp_pkg::*;
#(
    parameter int PWRUP_CYCLES = PWRUP_CYC
) (
    // Clock and reset.
    input  wire logic              clock,
    input  wire logic              resetn,
    // Request side.
    input  wire logic              req_valid,
    input  wire logic [CHAN_W-1:0] req_channel,
    input  wire logic              req_powerdown,
    input  wire logic              hold_cs_low,
    input  wire logic              eoc_gated_read,
    output logic                   req_ready,
    // Result side.
    output logic                   res_valid,
    output logic [DATA_W-1:0]      res_data,
    output logic [CHAN_W-1:0]      res_channel,
    input  wire logic              res_ready,
    output logic                   timeout_err,
    // Converter pins.
    output logic                   convert_start_n,
    output logic                   cs_n,
    output logic                   rd_n,
    output logic                   channel_sel_bit0,
    output logic                   channel_sel_bit1,
    output logic                   channel_sel_bit2,
    input  wire logic              eoc_n,
    input  wire logic [DATA_W-1:0] db_in
);
    localparam int BW = DATA_W + CHAN_W;

    sapp_stream_if #(.W(BW)) fill_s ();
    sapp_stream_if #(.W(BW)) drain_s ();

    sapp_buf2 #(.W(BW)) u_buf (
        .clock  (clock),
        .resetn (resetn),
        .in_s   (fill_s),
        .out_s  (drain_s)
    );

    // ***************************************************************
    // Pin synchronisers
    // ***************************************************************
    logic              eoc_s1_reg, eoc_s2_reg, eoc_s3_reg;
    logic [DATA_W-1:0] db_s1_reg, db_s2_reg;

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            eoc_s1_reg <= 1'b1;
            eoc_s2_reg <= 1'b1;
            eoc_s3_reg <= 1'b1;
            db_s1_reg  <= DATA_RST;
            db_s2_reg  <= DATA_RST;
        end else begin
            eoc_s1_reg <= eoc_n;
            eoc_s2_reg <= eoc_s1_reg;
            eoc_s3_reg <= eoc_s2_reg;
            db_s1_reg  <= db_in;
            db_s2_reg  <= db_s1_reg;
        end
    end

    // The pulse may be shorter than a cycle; a missed edge is covered by the timeout.
    logic eoc_fall;
    assign eoc_fall = eoc_s3_reg && !eoc_s2_reg;

    // ***************************************************************
    // Control
    // ***************************************************************
    sapp_state_t       st_reg, st_next;
    logic [CNT_W-1:0]  cnt_reg, cnt_next;
    logic              pd_reg, pd_next;
    logic              gated_reg, gated_next;
    logic              conv_reg, conv_next;
    logic              cs_reg, cs_next;
    logic              rd_reg, rd_next;
    logic [CHAN_W-1:0] ch_reg, ch_next;
    logic              to_reg, to_next;
    logic              vld_reg, vld_next;
    logic [BW-1:0]     wd_reg, wd_next;

    assign fill_s.valid  = vld_reg;
    assign fill_s.data   = wd_reg;
    assign drain_s.ready = res_ready || !res_valid;

    always_comb begin
        st_next    = st_reg;
        cnt_next   = cnt_reg;
        pd_next    = pd_reg;
        gated_next = gated_reg;
        conv_next  = conv_reg;
        cs_next    = cs_reg;
        rd_next    = rd_reg;
        ch_next    = ch_reg;
        to_next    = 1'b0;
        vld_next   = vld_reg && !fill_s.ready;
        wd_next    = wd_reg;
        case (st_reg)
            SAPP_IDLE: begin
                cs_next = !hold_cs_low;
                if (req_valid && !vld_reg) begin
                    ch_next    = req_channel;
                    pd_next    = req_powerdown;
                    gated_next = eoc_gated_read;
                    if (pd_reg) begin
                        conv_next = 1'b1;
                        cnt_next  = CNT_W'(PWRUP_CYCLES);
                        st_next   = SAPP_PWRUP;
                    end else begin
                        conv_next = 1'b0;
                        cnt_next  = CNT_W'(TIMEOUT_CYC);
                        st_next   = SAPP_CONV;
                    end
                end
            end
            SAPP_PWRUP: begin
                cnt_next = cnt_reg - 16'h0001;
                if (cnt_reg == 16'h0001) begin
                    conv_next = 1'b0;
                    cnt_next  = CNT_W'(TIMEOUT_CYC);
                    st_next   = SAPP_CONV;
                end
            end
            SAPP_CONV: begin
                cnt_next = cnt_reg - 16'h0001;
                // High speed releases convert-start before the pulse; power-down keeps it low.
                if (!pd_reg) begin
                    conv_next = 1'b1;
                end
                if (eoc_fall) begin
                    if (gated_reg) begin
                        // The bus is only driven inside the pulse, so take it on the edge.
                        vld_next = 1'b1;
                        wd_next  = {ch_reg, db_s2_reg};
                        st_next  = SAPP_READ;
                        cnt_next = 16'h0000;
                    end else begin
                        cs_next  = 1'b0;
                        rd_next  = 1'b0;
                        cnt_next = CNT_W'(RD_LOW_CYC);
                        st_next  = SAPP_READ;
                    end
                end else if (cnt_reg == 16'h0001) begin
                    to_next   = 1'b1;
                    cs_next   = 1'b0;
                    rd_next   = 1'b0;
                    cnt_next  = CNT_W'(RD_LOW_CYC);
                    st_next   = SAPP_READ;
                end
            end
            SAPP_READ: begin
                cs_next  = !hold_cs_low;
                if (cnt_reg > 16'h0001) begin
                    cs_next  = 1'b0;
                    cnt_next = cnt_reg - 16'h0001;
                end else begin
                    rd_next  = 1'b1;
                    vld_next = vld_next || !gated_reg;
                    wd_next  = gated_reg ? wd_reg : {ch_reg, db_s2_reg};
                    // The pin was held low through the pulse rise, fixing power-down.
                    conv_next = pd_reg ? 1'b0 : 1'b1;
                    cnt_next  = CNT_W'(REACQ_CYC);
                    st_next   = SAPP_REACQ;
                end
            end
            SAPP_REACQ: begin
                cnt_next = cnt_reg - 16'h0001;
                if (cnt_reg == 16'h0001) begin
                    st_next = SAPP_IDLE;
                end
            end
            default: begin
                st_next = SAPP_IDLE;
            end
        endcase
    end

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            st_reg    <= SAPP_IDLE;
            cnt_reg   <= 16'h0000;
            pd_reg    <= 1'b1;
            gated_reg <= 1'b0;
            conv_reg  <= 1'b1;
            cs_reg    <= 1'b1;
            rd_reg    <= 1'b1;
            ch_reg    <= CHAN_RST;
            to_reg    <= 1'b0;
            vld_reg   <= 1'b0;
            wd_reg    <= '0;
        end else begin
            st_reg    <= st_next;
            cnt_reg   <= cnt_next;
            pd_reg    <= pd_next;
            gated_reg <= gated_next;
            conv_reg  <= conv_next;
            cs_reg    <= cs_next;
            rd_reg    <= rd_next;
            ch_reg    <= ch_next;
            to_reg    <= to_next;
            vld_reg   <= vld_next;
            wd_reg    <= wd_next;
        end
    end

    // ***************************************************************
    // Output registers
    // ***************************************************************
    logic              rv_reg, rv_next;
    logic [BW-1:0]     rd_data_reg, rd_data_next;
    logic              rq_reg, rq_next;

    always_comb begin
        rv_next      = res_valid && !res_ready;
        rd_data_next = rd_data_reg;
        if (drain_s.valid && drain_s.ready) begin
            rv_next      = 1'b1;
            rd_data_next = drain_s.data;
        end
        rq_next = (st_next == SAPP_IDLE) && !vld_next;
    end

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            rv_reg      <= 1'b0;
            rd_data_reg <= '0;
            rq_reg      <= 1'b0;
        end else begin
            rv_reg      <= rv_next;
            rd_data_reg <= rd_data_next;
            rq_reg      <= rq_next;
        end
    end

    assign res_valid        = rv_reg;
    assign res_data         = rd_data_reg[DATA_W-1:0];
    assign res_channel      = rd_data_reg[BW-1:DATA_W];
    assign req_ready        = rq_reg;
    assign timeout_err      = to_reg;
    assign convert_start_n  = conv_reg;
    assign cs_n             = cs_reg;
    assign rd_n             = rd_reg;
    assign channel_sel_bit0 = ch_reg[0];
    assign channel_sel_bit1 = ch_reg[1];
    assign channel_sel_bit2 = ch_reg[2];

    // ***************************************************************
    // Checks
    // ***************************************************************
    AST_START_FALL: assert property (@(posedge clock) disable iff (!resetn)
        (st_reg != SAPP_CONV) ##1 (st_reg == SAPP_CONV) |-> !convert_start_n)
        else $error("conversion entered without start low");
    AST_RD_NEEDS_CS: assert property (@(posedge clock) disable iff (!resetn)
        $fell(rd_n) |-> !cs_n)
        else $error("read asserted without chip select");
    AST_CHAN_STABLE: assert property (@(posedge clock) disable iff (!resetn)
        !rd_n |-> $stable({channel_sel_bit2, channel_sel_bit1, channel_sel_bit0}))
        else $error("channel changed during read");
    AST_REACQ_GAP: assert property (@(posedge clock) disable iff (!resetn)
        $rose(rd_n) |-> (st_reg == SAPP_REACQ) ##1 (st_reg != SAPP_CONV))
        else $error("conversion started inside reacquire time");
    AST_PD_LOW: assert property (@(posedge clock) disable iff (!resetn)
        (st_reg == SAPP_CONV && pd_reg) |-> !convert_start_n)
        else $error("power-down start released early");
    AST_HS_HIGH: assert property (@(posedge clock) disable iff (!resetn)
        (st_reg == SAPP_CONV && !pd_reg) |=> convert_start_n || st_reg != SAPP_CONV)
        else $error("high-speed start not released");
    AST_RESULT_PUSH: assert property (@(posedge clock) disable iff (!resetn)
        $rose(rd_n) |-> vld_reg)
        else $error("read ended without storing result");
    AST_PWRUP_START: assert property (@(posedge clock) disable iff (!resetn)
        (st_reg == SAPP_PWRUP) |-> convert_start_n)
        else $error("start low during power-up");
    AST_TIMEOUT_BOUND: assert property (@(posedge clock) disable iff (!resetn)
        $rose(st_reg == SAPP_CONV) |-> ##[1:70] (st_reg != SAPP_CONV))
        else $error("conversion never ended");

    COV_HS: cover property (@(posedge clock) st_reg == SAPP_READ && !pd_reg);
    COV_PD: cover property (@(posedge clock) st_reg == SAPP_PWRUP);
    COV_GATED: cover property (@(posedge clock) st_reg == SAPP_READ && gated_reg);
    COV_FULL: cover property (@(posedge clock) !fill_s.ready);
endmodule : sapp_host

// File: sapp_conv_model.sv
`timescale 1ns/100ps
// ***************************************************************
// Converter model
// ***************************************************************
// The bus is not pulled, so a released bus shows the inverse of the result.
module sapp_conv_model #(
    parameter int PWRUP_NS = 400
) (
    input  wire logic       convert_start_n,
    input  wire logic       cs_n,
    input  wire logic       rd_n,
    input  wire logic [2:0] chan,
    input  wire logic       mute,
    output logic            eoc_n,
    output logic [7:0]      db,
    output logic [2:0]      last_chan,
    output int              viol
);
    logic     powered;
    logic [7:0] out_reg;
    logic [7:0] conv_n;
    realtime  up_t;
    realtime  rd_up_t;
    initial begin
        eoc_n = 1'b1;
        powered = 1'b0;
        out_reg = 8'h00;
        conv_n = 8'h00;
        last_chan = 3'h0;
        viol = 0;
        up_t = 0;
        rd_up_t = -1000;
    end
    assign db = (!cs_n && !rd_n) ? out_reg : ~out_reg;
    always @(posedge convert_start_n) begin
        if (!powered) begin
            powered = 1'b1;
            up_t = $realtime;
        end
    end
    always @(negedge rd_n) last_chan = chan;
    always @(posedge rd_n) begin
        rd_up_t = $realtime;
        eoc_n = 1'b1;
    end
    always @(posedge eoc_n) begin
        if (convert_start_n === 1'b0) powered = 1'b0;
    end
    always @(negedge convert_start_n) begin
        if (!powered || ($realtime - up_t) < PWRUP_NS) viol++;
        if (($realtime - rd_up_t) < 30) viol++;
        #420;
        conv_n = conv_n + 8'h01;
        out_reg = 8'h5a ^ conv_n;
        if (!mute) begin
            eoc_n = 1'b0;
            #105;
            eoc_n = 1'b1;
        end
    end
endmodule : sapp_conv_model

// File: tb_sampling_adc_parallel_port.sv
`timescale 1ns/100ps
module tb_sampling_adc_parallel_port;
    import sapp_pkg::*;
    typedef struct {logic [2:0] ch; logic pd; logic hold; logic gate; logic [7:0] dat;} sapp_row_t;
    logic clock = 1'b0, resetn = 1'b0, req_valid = 1'b0, req_powerdown = 1'b0;
    logic hold_cs_low = 1'b0, eoc_gated_read = 1'b0, res_ready = 1'b1, mute = 1'b0;
    logic [2:0] req_channel = 3'h0, res_channel, last_chan;
    logic [7:0] res_data, db;
    logic req_ready, res_valid, timeout_err, convert_start_n, cs_n, rd_n, eoc_n;
    logic b0, b1, b2;
    int failures = 0, num_checks = 0, viol, n = 0, acc;
    sapp_row_t rows [8] = '{'{3'h0,0,0,0,8'h5b}, '{3'h1,0,1,0,8'h58}, '{3'h2,0,0,0,8'h59},
                            '{3'h3,1,0,0,8'h5e}, '{3'h4,0,0,0,8'h5f}, '{3'h5,0,1,0,8'h5c},
                            '{3'h6,0,0,1,8'h5d}, '{3'h7,1,0,1,8'h52}};
    sapp_host #(.PWRUP_CYCLES(4)) dut_u (.clock(clock), .resetn(resetn),
        .req_valid(req_valid), .req_channel(req_channel), .req_powerdown(req_powerdown),
        .hold_cs_low(hold_cs_low), .eoc_gated_read(eoc_gated_read), .req_ready(req_ready),
        .res_valid(res_valid), .res_data(res_data), .res_channel(res_channel),
        .res_ready(res_ready), .timeout_err(timeout_err), .convert_start_n(convert_start_n),
        .cs_n(cs_n), .rd_n(rd_n), .channel_sel_bit0(b0), .channel_sel_bit1(b1),
        .channel_sel_bit2(b2), .eoc_n(eoc_n), .db_in(db));
    // In the gated wiring the converter's select and read follow its own end pulse.
    sapp_conv_model #(.PWRUP_NS(400)) conv_u (.convert_start_n(convert_start_n),
        .cs_n(eoc_gated_read ? eoc_n : cs_n), .rd_n(eoc_gated_read ? eoc_n : rd_n),
        .chan({b2, b1, b0}), .mute(mute), .eoc_n(eoc_n), .db(db),
        .last_chan(last_chan), .viol(viol));
    initial forever #50 clock = ~clock;
    task automatic check(input string name, input logic [7:0] exp, input logic [7:0] got);
        num_checks++;
        if (got !== exp) begin
            failures++;
            $display("[FAIL] %s expected %h seen %h", name, exp, got);
        end
    endtask : check
    task automatic give_verdict;
        $display("checks %0d mismatches %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : give_verdict
    // Raise a request at a falling edge and hold it until it is taken or lim cycles pass.
    task automatic send(input sapp_row_t r, input int lim, output bit taken);
        int k;
        req_channel = r.ch;
        req_powerdown = r.pd;
        hold_cs_low = r.hold;
        eoc_gated_read = r.gate;
        req_valid = 1'b1;
        taken = 0;
        for (k = 0; k < lim && !taken; k++) begin
            // A ready seen here is what the next rising edge samples with the request.
            taken = (req_ready === 1'b1);
            @(negedge clock);
        end
        req_valid = 1'b0;
    endtask : send
    task automatic take(input logic [2:0] ch);
        int k;
        for (k = 0; k < 200 && res_valid !== 1'b1; k++) @(negedge clock);
        n++;
        check("res_valid", 8'h01, {7'h0, res_valid});
        check("res_data", 8'h5a ^ n[7:0], res_data);
        check("res_channel", {5'h0, ch}, {5'h0, res_channel});
        @(negedge clock);
    endtask : take
    initial begin
        bit t;
        int k;
        bit seen;
        repeat (4) @(negedge clock);
        check("convert_start_n", 8'h01, {7'h0, convert_start_n});
        check("rd_n", 8'h01, {7'h0, rd_n});
        resetn = 1'b1;
        @(negedge clock);
        check("req_ready", 8'h01, {7'h0, req_ready});
        foreach (rows[i]) begin
            send(rows[i], 600, t);
            take(rows[i].ch);
            check("row res_data", rows[i].dat, res_data);
            if (!rows[i].gate) check("last_chan", {5'h0, rows[i].ch}, {5'h0, last_chan});
            repeat (3) @(negedge clock);
            check("cs_n idle", {7'h0, !rows[i].hold}, {7'h0, cs_n});
        end
        // Receiver stall: one word at the output, two buffered, one pending, then refusal.
        res_ready = 1'b0;
        acc = 0;
        for (k = 0; k < 5; k++) begin
            send('{3'(k + 1), 1'b0, 1'b0, 1'b0, 8'h00}, 300, t);
            acc += t;
            @(negedge clock);
        end
        check("accepted", 8'h04, 8'(acc));
        res_ready = 1'b1;
        for (k = 0; k < 4; k++) take(3'(k + 1));
        // Silent converter: timeout, then a read outside the pulse.
        mute = 1'b1;
        fork
            send('{3'h2, 1'b0, 1'b0, 1'b0, 8'h00}, 600, t);
            begin
                seen = 0;
                for (k = 0; k < 200 && !seen; k++) begin
                    @(negedge clock);
                    seen = (timeout_err === 1'b1);
                end
            end
        join
        check("timeout_err", 8'h01, {7'h0, seen});
        take(3'h2);
        mute = 1'b0;
        send('{3'h5, 1'b0, 1'b0, 1'b0, 8'h00}, 600, t);
        take(3'h5);
        check("converter timing", 8'h00, 8'(viol));
        // Reset in mid-conversion.
        send('{3'h1, 1'b0, 1'b0, 1'b0, 8'h00}, 600, t);
        resetn = 1'b0;
        @(negedge clock);
        check("convert_start_n rst", 8'h01, {7'h0, convert_start_n});
        check("res_valid rst", 8'h00, {7'h0, res_valid});
        check("cs_n rst", 8'h01, {7'h0, cs_n});
        give_verdict();
    end
    initial begin
        #3000000;
        failures++;
        give_verdict();
    end
endmodule : tb_sampling_adc_parallel_port
